// ### design/seqldr_consts.svh
// constant offsets, field positions, reset values and sizes of the startup loader
`ifndef SEQLDR_CONSTS_SVH
`define SEQLDR_CONSTS_SVH
// register offsets in the control register space
`define SEQLDR_OFF_CTRL       8'h07
`define SEQLDR_OFF_OPTS       8'h08
`define SEQLDR_OFF_PTR_LO     8'heb
`define SEQLDR_OFF_PTR_HI     8'hec
// startup control field positions
`define SEQLDR_BIT_AUTO_LOAD  0
`define SEQLDR_BIT_AUTO_START 1
`define SEQLDR_BIT_ALT_BOOT   2
// startup option field position
`define SEQLDR_BIT_XTND_INIT  2
// reset values
`define SEQLDR_RST_CTRL       8'h00
`define SEQLDR_RST_OPTS       8'h00
`define SEQLDR_RST_TBL_PTR    16'h0f00
// nonvolatile image base and length of the basic load
`define SEQLDR_EE_BASE        12'h000
`define SEQLDR_AUTO_LEN       9'h100
// address widths and fifo depth
`define SEQLDR_EE_AW          12
`define SEQLDR_REG_AW         14
`define SEQLDR_FIFO_DEPTH     4
`endif

// ### design/seqldr_pkg.sv
// types shared by the startup loader modules
package seqldr_pkg;
  // one-hot sequencer states
  typedef enum logic [8:0] {
    ST_STRAP = 9'h001,
    ST_CFG   = 9'h002,
    ST_AUTO  = 9'h004,
    ST_XI    = 9'h008,
    ST_PTR   = 9'h010,
    ST_CHECK = 9'h020,
    ST_COPY  = 9'h040,
    ST_DRAIN = 9'h080,
    ST_DONE  = 9'h100
  } seqldr_state_t;
  // which table pointer is being assembled
  typedef enum logic [1:0] {
    PS_END  = 2'h0,
    PS_SRC  = 2'h1,
    PS_DST  = 2'h2,
    PS_DEND = 2'h3
  } seqldr_psel_t;
endpackage : seqldr_pkg

// ### design/seqldr_fifo.sv
// small flop-based fifo with valid/ready on both sides
`timescale 1ns/1ps
module seqldr_fifo #(
  parameter int WIDTH = 22,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_in,
  input  wire logic             rstn_in,
  input  wire logic             ce_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];   // storage words
  logic [AW-1:0]    wr_idx;        // write index
  logic [AW-1:0]    rd_idx;        // read index
  logic [AW:0]      fill;          // words held
  logic             push;          // word accepted
  logic             pop;           // word taken

  // honest full and empty flags
  assign in_ready_out  = (fill != (AW+1)'(DEPTH));
  assign out_valid_out = (fill != '0);
  assign out_data_out  = mem[rd_idx];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  // index wrap helper
  function automatic logic [AW-1:0] step_idx(input logic [AW-1:0] idx);
    step_idx = (idx == AW'(DEPTH - 1)) ? '0 : AW'(idx + 1'b1);
  endfunction : step_idx

  // storage write
  always_ff @(posedge clk_in) begin
    if (ce_in && push) begin
      mem[wr_idx] <= in_data_in;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      wr_idx <= '0;
      rd_idx <= '0;
      fill   <= '0;
    end else if (ce_in) begin
      if (push) begin
        wr_idx <= step_idx(wr_idx);
      end
      if (pop) begin
        rd_idx <= step_idx(rd_idx);
      end
      if (push && !pop) begin
        fill <= (AW+1)'(fill + 1'b1);
      end else if (pop && !push) begin
        fill <= (AW+1)'(fill - 1'b1);
      end
    end
  end
endmodule : seqldr_fifo

// ### design/seqldr_top.sv
// startup sequencer: basic load, extended table-driven init, run mode choice
`timescale 1ns/1ps
`include "seqldr_consts.svh"
module seqldr_top
  import seqldr_pkg::*;
#(
  parameter int               EE_AW    = `SEQLDR_EE_AW,
  parameter int               REG_AW   = `SEQLDR_REG_AW,
  parameter int               DEPTH    = `SEQLDR_FIFO_DEPTH,
  parameter logic [8:0]       AUTO_LEN = `SEQLDR_AUTO_LEN,
  parameter logic [EE_AW-1:0] EE_BASE  = `SEQLDR_EE_BASE
) (
  input  wire logic              SYS_CLK_IN,
  input  wire logic              RSTN_IN,
  input  wire logic              CE_IN,
  input  wire logic              SAMPLE_READY_STRAP_IN,
  input  wire logic              START_CMD_IN,
  output logic                   EE_RD_REQ_OUT,
  output logic [EE_AW-1:0]       EE_ADDR_OUT,
  input  wire logic              EE_RD_VALID_IN,
  input  wire logic [7:0]        EE_DATA_IN,
  output logic                   REG_WR_VALID_OUT,
  output logic [REG_AW-1:0]      REG_WR_ADDR_OUT,
  output logic [7:0]             REG_WR_DATA_OUT,
  input  wire logic              REG_WR_READY_IN,
  input  wire logic              HOST_WR_IN,
  input  wire logic [7:0]        HOST_ADDR_IN,
  input  wire logic [7:0]        HOST_WDATA_IN,
  output logic [7:0]             HOST_RDATA_OUT,
  output logic                   BUSY_OUT,
  output logic                   RUN_MODE_OUT
);
  ////////////////////////////////////////////////////////////////////////////
  // declarations
  seqldr_state_t     state;        // sequencer state
  seqldr_psel_t      psel;         // pointer being assembled
  logic              byte_hi;      // next table byte is the high byte
  logic [7:0]        ptr_lo;       // held low byte of a pointer
  logic [8:0]        cnt;          // basic load / option byte counter
  logic [15:0]       tbl_ptr;      // current table read address
  logic [15:0]       end_ptr;      // table end pointer
  logic [15:0]       src;          // copy source address
  logic [15:0]       dst;          // copy destination address
  logic [15:0]       dst_end;      // last destination address
  logic [7:0]        ctrl;         // startup_control
  logic [7:0]        opts;         // startup_options
  logic [7:0]        ptr_a;        // init_table_pointer_a, low byte
  logic [7:0]        ptr_b;        // init_table_pointer_b, high byte
  logic              ee_take;      // eeprom byte arrives
  logic              push_pend;    // a register write waits for the fifo
  logic [REG_AW-1:0] push_addr;    // its address
  logic [7:0]        push_data;    // its data
  logic              fifo_in_rdy;  // fifo accepts
  logic              fifo_o_vld;   // fifo holds a word
  logic              fifo_o_rdy;   // output stage takes a word
  logic [REG_AW+7:0] fifo_o_dat;   // fifo head word
  logic              push_fire;    // write enters fifo
  logic              drain_ok;     // all writes delivered
  logic              rd_state;     // state that reads eeprom
  logic [EE_AW-1:0]  rd_addr;      // address for next read
  logic [15:0]       ptr_val;      // assembled pointer

  assign ee_take   = EE_RD_REQ_OUT && EE_RD_VALID_IN;
  assign push_fire = push_pend && fifo_in_rdy;
  assign drain_ok  = !push_pend && !fifo_o_vld && !REG_WR_VALID_OUT;
  assign ptr_val   = {EE_DATA_IN, ptr_lo};
  assign rd_state  = (state == ST_CFG) || (state == ST_AUTO) ||
                     (state == ST_PTR) || (state == ST_COPY);

  // 16-bit address increment
  function automatic logic [15:0] inc16(input logic [15:0] a);
    inc16 = 16'(a + 16'h0001);
  endfunction : inc16

  // read address per state
  always_comb begin
    unique case (state)
      ST_CFG:  rd_addr = EE_AW'(EE_BASE + EE_AW'(`SEQLDR_OFF_CTRL) + EE_AW'(cnt));
      ST_AUTO: rd_addr = EE_AW'(EE_BASE + EE_AW'(cnt));
      ST_PTR:  rd_addr = tbl_ptr[EE_AW-1:0];
      ST_COPY: rd_addr = src[EE_AW-1:0];
      default: rd_addr = '0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // eeprom read port: request held until the byte arrives
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RSTN_IN) begin
      EE_RD_REQ_OUT <= 1'b0;
      EE_ADDR_OUT   <= '0;
    end else if (CE_IN) begin
      if (ee_take) begin
        EE_RD_REQ_OUT <= 1'b0;
      end else if (rd_state && !EE_RD_REQ_OUT && !push_pend) begin
        EE_RD_REQ_OUT <= 1'b1;
        EE_ADDR_OUT   <= rd_addr;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RSTN_IN) begin
      state    <= ST_STRAP;
      psel     <= PS_END;
      byte_hi  <= 1'b0;
      ptr_lo   <= 8'h00;
      cnt      <= '0;
      tbl_ptr  <= 16'h0000;
      end_ptr  <= 16'h0000;
      src      <= 16'h0000;
      dst      <= 16'h0000;
      dst_end  <= 16'h0000;
      BUSY_OUT <= 1'b1;
      RUN_MODE_OUT <= 1'b0;
    end else if (CE_IN) begin
      unique case (state)
        // strap seen after reset release
        ST_STRAP: begin
          if (SAMPLE_READY_STRAP_IN) begin
            state    <= ST_DONE;
            BUSY_OUT <= 1'b0;
          end else begin
            state <= ST_CFG;
          end
        end
        // fetch nonvolatile control and option bytes
        ST_CFG: begin
          if (ee_take) begin
            if (cnt == 9'h000) begin
              cnt <= 9'h001;
            end else begin
              cnt   <= '0;
              state <= ctrl[`SEQLDR_BIT_AUTO_LOAD] ? ST_AUTO : ST_XI;
            end
          end
        end
        // basic load of the first 256 image bytes
        ST_AUTO: begin
          if (ee_take) begin
            if (cnt == 9'(AUTO_LEN - 9'h001)) begin
              cnt   <= '0;
              state <= ST_XI;
            end else begin
              cnt <= 9'(cnt + 9'h001);
            end
          end
        end
        // extended init gate, after the pending write entered the fifo
        ST_XI: begin
          if (!push_pend) begin
            if (ctrl[`SEQLDR_BIT_ALT_BOOT] && opts[`SEQLDR_BIT_XTND_INIT]) begin
              tbl_ptr <= {ptr_b, ptr_a};
              psel    <= PS_END;
              byte_hi <= 1'b0;
              state   <= ST_PTR;
            end else begin
              state <= ST_DRAIN;
            end
          end
        end
        // assemble one pointer, low byte first
        ST_PTR: begin
          if (ee_take) begin
            tbl_ptr <= inc16(tbl_ptr);
            if (!byte_hi) begin
              ptr_lo  <= EE_DATA_IN;
              byte_hi <= 1'b1;
            end else begin
              byte_hi <= 1'b0;
              unique case (psel)
                PS_END: begin
                  end_ptr <= ptr_val;
                  state   <= ST_CHECK;
                end
                PS_SRC: begin
                  src  <= ptr_val;
                  psel <= PS_DST;
                end
                PS_DST: begin
                  dst  <= ptr_val;
                  psel <= PS_DEND;
                end
                PS_DEND: begin
                  dst_end <= ptr_val;
                  state   <= ST_COPY;
                end
              endcase
            end
          end
        end
        // stop when the table end is reached
        ST_CHECK: begin
          if (tbl_ptr >= end_ptr) begin
            state <= ST_DRAIN;
          end else begin
            psel  <= PS_SRC;
            state <= ST_PTR;
          end
        end
        // copy one byte per read into the destination range
        ST_COPY: begin
          if (ee_take) begin
            src <= inc16(src);
            if (dst == dst_end) begin
              state <= ST_CHECK;
            end else begin
              dst <= inc16(dst);
            end
          end
        end
        // wait for every write, then choose the mode
        ST_DRAIN: begin
          if (drain_ok) begin
            state        <= ST_DONE;
            BUSY_OUT     <= 1'b0;
            RUN_MODE_OUT <= ctrl[`SEQLDR_BIT_AUTO_LOAD] &&
                            ctrl[`SEQLDR_BIT_AUTO_START];
          end
        end
        // configure mode until a start command
        ST_DONE: begin
          if (START_CMD_IN) begin
            RUN_MODE_OUT <= 1'b1;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pending register write produced by the load or the copy
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RSTN_IN) begin
      push_pend <= 1'b0;
      push_addr <= '0;
      push_data <= 8'h00;
    end else if (CE_IN) begin
      if (ee_take && state == ST_AUTO) begin
        push_pend <= 1'b1;
        push_addr <= REG_AW'(cnt);
        push_data <= EE_DATA_IN;
      end else if (ee_take && state == ST_COPY) begin
        push_pend <= 1'b1;
        push_addr <= dst[REG_AW-1:0];
        push_data <= EE_DATA_IN;
      end else if (push_fire) begin
        push_pend <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // local startup registers: cfg fetch, snooped writes, host writes
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RSTN_IN) begin
      ctrl  <= `SEQLDR_RST_CTRL;
      opts  <= `SEQLDR_RST_OPTS;
      ptr_a <= 8'(`SEQLDR_RST_TBL_PTR & 16'h00ff);
      ptr_b <= 8'(`SEQLDR_RST_TBL_PTR >> 8);
    end else if (CE_IN) begin
      if (ee_take && state == ST_CFG) begin
        if (cnt == 9'h000) begin
          ctrl <= EE_DATA_IN;
        end else begin
          opts <= EE_DATA_IN;
        end
      end else if (push_fire && push_addr[REG_AW-1:8] == '0) begin
        // loaded value replaces the default pointer
        unique case (push_addr[7:0])
          `SEQLDR_OFF_CTRL:   ctrl  <= push_data;
          `SEQLDR_OFF_OPTS:   opts  <= push_data;
          `SEQLDR_OFF_PTR_LO: ptr_a <= push_data;
          `SEQLDR_OFF_PTR_HI: ptr_b <= push_data;
          default: ;
        endcase
      end else if (HOST_WR_IN && !BUSY_OUT) begin
        // host writes refused while startup runs
        unique case (HOST_ADDR_IN)
          `SEQLDR_OFF_CTRL:   ctrl  <= HOST_WDATA_IN;
          `SEQLDR_OFF_OPTS:   opts  <= HOST_WDATA_IN;
          `SEQLDR_OFF_PTR_LO: ptr_a <= HOST_WDATA_IN;
          `SEQLDR_OFF_PTR_HI: ptr_b <= HOST_WDATA_IN;
          default: ;
        endcase
      end
    end
  end

  // registered readback, unmapped offsets read zero
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RSTN_IN) begin
      HOST_RDATA_OUT <= 8'h00;
    end else if (CE_IN) begin
      unique case (HOST_ADDR_IN)
        `SEQLDR_OFF_CTRL:   HOST_RDATA_OUT <= ctrl;
        `SEQLDR_OFF_OPTS:   HOST_RDATA_OUT <= opts;
        `SEQLDR_OFF_PTR_LO: HOST_RDATA_OUT <= ptr_a;
        `SEQLDR_OFF_PTR_HI: HOST_RDATA_OUT <= ptr_b;
        default:            HOST_RDATA_OUT <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write buffer and registered output stage
  seqldr_fifo #(
    .WIDTH (REG_AW + 8),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_in        (SYS_CLK_IN),
    .rstn_in       (RSTN_IN),
    .ce_in         (CE_IN),
    .in_valid_in   (push_pend),
    .in_ready_out  (fifo_in_rdy),
    .in_data_in    ({push_addr, push_data}),
    .out_valid_out (fifo_o_vld),
    .out_ready_in  (fifo_o_rdy),
    .out_data_out  (fifo_o_dat)
  );

  assign fifo_o_rdy = !REG_WR_VALID_OUT || REG_WR_READY_IN;

  // output word held until the register port takes it
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RSTN_IN) begin
      REG_WR_VALID_OUT <= 1'b0;
      REG_WR_ADDR_OUT  <= '0;
      REG_WR_DATA_OUT  <= 8'h00;
    end else if (CE_IN) begin
      if (fifo_o_rdy) begin
        REG_WR_VALID_OUT <= fifo_o_vld;
        if (fifo_o_vld) begin
          {REG_WR_ADDR_OUT, REG_WR_DATA_OUT} <= fifo_o_dat;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_byte_in;
    CE_IN && ee_take;
  endsequence

  sequence s_drain_end;
    CE_IN && state == ST_DRAIN && drain_ok;
  endsequence

  a_strap_bypass: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    CE_IN && state == ST_STRAP && SAMPLE_READY_STRAP_IN |=> state == ST_DONE && !BUSY_OUT && !RUN_MODE_OUT)
    else $error("strap did not bypass startup");

  a_busy_during: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    state != ST_DONE |-> BUSY_OUT)
    else $error("busy low during startup");

  a_xi_gate_off: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    CE_IN && state == ST_XI && !push_pend &&
    !(ctrl[`SEQLDR_BIT_ALT_BOOT] && opts[`SEQLDR_BIT_XTND_INIT]) |=> state == ST_DRAIN)
    else $error("extended init entered without both flags");

  a_xi_table_start: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    CE_IN && state == ST_XI && !push_pend && ctrl[`SEQLDR_BIT_ALT_BOOT] && opts[`SEQLDR_BIT_XTND_INIT]
    |=> state == ST_PTR && tbl_ptr == {$past(ptr_b), $past(ptr_a)})
    else $error("table read did not start at pointer registers");

  a_copy_data: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    s_byte_in and state == ST_COPY |=> push_pend && push_data == $past(EE_DATA_IN) &&
    push_addr == $past(dst[REG_AW-1:0]))
    else $error("copied byte or destination wrong");

  a_empty_table: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    CE_IN && state == ST_CHECK && tbl_ptr >= end_ptr |=> state == ST_DRAIN)
    else $error("copy started past table end");

  a_run_choice: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    s_drain_end |=> RUN_MODE_OUT == ($past(ctrl[`SEQLDR_BIT_AUTO_LOAD]) && $past(ctrl[`SEQLDR_BIT_AUTO_START])))
    else $error("run mode choice wrong");

  a_ptr_default: assert property (@(posedge SYS_CLK_IN)
    !$past(RSTN_IN) && RSTN_IN |-> {ptr_b, ptr_a} == `SEQLDR_RST_TBL_PTR)
    else $error("pointer default wrong after reset");

  a_load_order: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    s_byte_in and state == ST_CFG && cnt == 9'h001 |=>
    state == (ctrl[`SEQLDR_BIT_AUTO_LOAD] ? ST_AUTO : ST_XI))
    else $error("basic load decision wrong");
endmodule : seqldr_top

// ### tb/seqldr_ee_model.sv
// model of the eeprom read port and the register write port beside the startup loader
`timescale 1ns/1ps
module seqldr_ee_model (
  input  wire logic        clk_in,
  input  wire logic        slow_in,
  input  wire logic        rd_req_in,
  input  wire logic [11:0] rd_addr_in,
  output logic             rd_valid_out,
  output logic [7:0]       rd_data_out,
  input  wire logic        wr_valid_in,
  input  wire logic [13:0] wr_addr_in,
  input  wire logic [7:0]  wr_data_in,
  output logic             wr_ready_out
);
  logic [7:0] ee [0:4095];     // nonvolatile image, filled by the bench
  logic [7:0] rimg [0:16383];  // register space as written
  int         nrd = 0;         // bytes answered
  int         nwr = 0;         // words taken
  logic [2:0] dly = 3'h0;      // pacing of slow answers and stalls
  logic [7:0] last = 8'h00;    // last byte driven
  initial rd_valid_out = 1'b0;
  // one byte per request, at once or after a wait; pointer bytes pair little endian
  always @(posedge clk_in) begin
    dly <= dly + 3'h1;
    if (rd_req_in && !rd_valid_out && (!slow_in || dly == 3'h7)) begin
      rd_valid_out <= 1'b1;
      last         <= ee[rd_addr_in];
      nrd          <= nrd + 1;
    end else begin
      rd_valid_out <= 1'b0;
    end
  end
  // released data lines show the inverse so stale bytes never pass
  assign rd_data_out  = rd_valid_out ? last : ~last;
  // register port stalls seven cycles of eight when slow, paced like the slow reads, so the fifo holds at most one word
  assign wr_ready_out = !slow_in || dly == 3'h7;
  always @(posedge clk_in) begin
    if (wr_valid_in && wr_ready_out) begin
      rimg[wr_addr_in] <= wr_data_in;
      nwr              <= nwr + 1;
    end
  end
endmodule : seqldr_ee_model

// ### tb/tb_startup_extended_init_loader.sv
// self-checking bench for the startup loader with its memory model
`timescale 1ns/1ps
module tb_startup_extended_init_loader;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        strap = 1'b0;
  logic        start = 1'b0;
  logic        slow = 1'b0;
  logic        ce = 1'b1;
  logic        eereq;
  logic [11:0] eeadr;
  logic        eevld;
  logic [7:0]  eedat;
  logic        wrv;
  logic [13:0] wra;
  logic [7:0]  wrd;
  logic        wrr;
  logic        hwr = 1'b0;
  logic [7:0]  hadr = 8'h00;
  logic [7:0]  hwd = 8'h00;
  logic [7:0]  hrd;
  logic        busy;
  logic        run;
  int          miscompares = 0;
  int          num_checks = 0;
  //////////////////////////////////////////////////////////////////////////
  always #5 clk = ~clk;
  seqldr_top seqldr_top_i (.SYS_CLK_IN(clk), .RSTN_IN(rstn), .CE_IN(ce), .SAMPLE_READY_STRAP_IN(strap),
    .START_CMD_IN(start), .EE_RD_REQ_OUT(eereq), .EE_ADDR_OUT(eeadr), .EE_RD_VALID_IN(eevld),
    .EE_DATA_IN(eedat), .REG_WR_VALID_OUT(wrv), .REG_WR_ADDR_OUT(wra), .REG_WR_DATA_OUT(wrd),
    .REG_WR_READY_IN(wrr), .HOST_WR_IN(hwr), .HOST_ADDR_IN(hadr), .HOST_WDATA_IN(hwd),
    .HOST_RDATA_OUT(hrd), .BUSY_OUT(busy), .RUN_MODE_OUT(run));
  seqldr_ee_model seqldr_ee_model_i (.clk_in(clk), .slow_in(slow), .rd_req_in(eereq), .rd_addr_in(eeadr),
    .rd_valid_out(eevld), .rd_data_out(eedat), .wr_valid_in(wrv), .wr_addr_in(wra), .wr_data_in(wrd),
    .wr_ready_out(wrr));
  //////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic chk(input string w, input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", w, e, s);
    end
  endtask : chk
  task automatic stop_test();
    if (miscompares == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  // image pattern, control and option bytes, then a reset of ten cycles
  task automatic boot(input logic [7:0] c, input logic [7:0] o, input logic s);
    foreach (seqldr_ee_model_i.ee[i]) seqldr_ee_model_i.ee[i] = 8'(i) ^ 8'h5a;
    foreach (seqldr_ee_model_i.rimg[i]) seqldr_ee_model_i.rimg[i] = 8'h00;
    seqldr_ee_model_i.ee[7] = c;
    seqldr_ee_model_i.ee[8] = o;
    @(negedge clk);
    rstn = 1'b0;
    strap = s;
    repeat (10) @(negedge clk);
    // counters cleared once the port has gone quiet in reset
    seqldr_ee_model_i.nrd = 0;
    seqldr_ee_model_i.nwr = 0;
    rstn = 1'b1;
    @(negedge clk);
    strap = 1'b0;
  endtask : boot
  task automatic idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 20000) begin
      @(negedge clk);
      n++;
    end
    chk("busy", {15'h0, busy}, 16'h0000);
  endtask : idle
  task automatic hwrite(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    hadr = a;
    hwd = d;
    hwr = 1'b1;
    @(negedge clk);
    hwr = 1'b0;
  endtask : hwrite
  task automatic hread(input string w, input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    hadr = a;
    @(negedge clk);
    chk(w, {8'h0, hrd}, {8'h0, e});
  endtask : hread
  // table: end pointer, then descriptors of four bytes and one byte, or none
  task automatic put16(input logic [11:0] a, input logic [15:0] v);
    seqldr_ee_model_i.ee[a] = v[7:0];
    seqldr_ee_model_i.ee[a + 12'h1] = v[15:8];
  endtask : put16
  //////////////////////////////////////////////////////////////////////////
  // strap high skips startup; host port and start command still work
  task automatic t_bypass();
    boot(8'h03, 8'h04, 1'b1);
    idle();
    chk("reads", 16'(seqldr_ee_model_i.nrd), 16'h0000);
    chk("run", {15'h0, run}, 16'h0000);
    // a start command with the clock enable low must be ignored
    @(negedge clk);
    ce = 1'b0;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    @(negedge clk);
    ce = 1'b1;
    chk("run frozen", {15'h0, run}, 16'h0000);
    @(negedge clk);
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    @(negedge clk);
    chk("run cmd", {15'h0, run}, 16'h0001);
    hwrite(8'h07, 8'ha5);
    hread("ctrl", 8'h07, 8'ha5);
    hread("unmapped", 8'h40, 8'h00);
  endtask : t_bypass
  // no auto-load, alternate boot clear: no copy, default pointer, configure mode
  task automatic t_no_load();
    boot(8'h00, 8'h04, 1'b0);
    idle();
    chk("writes", 16'(seqldr_ee_model_i.nwr), 16'h0000);
    chk("run", {15'h0, run}, 16'h0000);
    hread("ptr a", 8'heb, 8'h00);
    hread("ptr b", 8'hec, 8'h0f);
  endtask : t_no_load
  // auto-load under stalls, restarted by reset in mid-run, then auto-start
  task automatic t_autoload();
    slow = 1'b1;
    boot(8'h03, 8'h00, 1'b0);
    repeat (60) @(negedge clk);
    // host write while busy must be dropped
    hwrite(8'h07, 8'h00);
    hread("ctrl busy", 8'h07, 8'h03);
    boot(8'h03, 8'h00, 1'b0);
    idle();
    slow = 1'b0;
    chk("writes", 16'(seqldr_ee_model_i.nwr), 16'h0100);
    for (int i = 0; i < 256; i++) begin
      chk("image", {8'h0, seqldr_ee_model_i.rimg[i]}, {8'h0, seqldr_ee_model_i.ee[i]});
    end
    chk("run", {15'h0, run}, 16'h0001);
    hread("ctrl", 8'h07, 8'h03);
    hread("ptr a", 8'heb, 8'heb ^ 8'h5a);
  endtask : t_autoload
  // extended init cases: control, options, descriptor count, table base, writes expected
  task automatic t_xinit();
    logic [7:0]  c [4] = '{8'h04, 8'h04, 8'h04, 8'h05};
    logic [7:0]  o [4] = '{8'h04, 8'h00, 8'h04, 8'h04};
    int          n [4] = '{2, 2, 0, 2};
    logic [11:0] b [4] = '{12'hf00, 12'hf00, 12'hf00, 12'he00};
    int          e [4] = '{5, 0, 0, 261};
    for (int k = 0; k < 4; k++) begin
      boot(c[k], o[k], 1'b0);
      seqldr_ee_model_i.ee[12'heb] = 8'h00;
      seqldr_ee_model_i.ee[12'hec] = 8'(b[k] >> 8);
      put16(b[k], 16'(b[k]) + 16'h2 + 16'(6 * n[k]));
      put16(b[k] + 12'h2, 16'h0100);
      put16(b[k] + 12'h4, 16'h0200);
      put16(b[k] + 12'h6, 16'h0203);
      put16(b[k] + 12'h8, 16'h0110);
      put16(b[k] + 12'ha, 16'h0300);
      put16(b[k] + 12'hc, 16'h0300);
      idle();
      chk("writes", 16'(seqldr_ee_model_i.nwr), 16'(e[k]));
      if (e[k] > 0) begin
        for (int i = 0; i < 4; i++) begin
          chk("block", {8'h0, seqldr_ee_model_i.rimg[14'h200 + i]}, {8'h0, 8'(i) ^ 8'h5a});
        end
        chk("last", {8'h0, seqldr_ee_model_i.rimg[14'h300]}, {8'h0, 8'h10 ^ 8'h5a});
      end
    end
  endtask : t_xinit
  //////////////////////////////////////////////////////////////////////////
  initial begin
    t_bypass();
    t_no_load();
    t_autoload();
    t_xinit();
    stop_test();
  end
  // watchdog well beyond the expected run of about 4000 cycles
  initial begin
    repeat (80000) @(posedge clk);
    miscompares++;
    stop_test();
  end
endmodule : tb_startup_extended_init_loader
